// ### rtl/dsc_decode_defines.vh
// constants for the instruction decode and cycle timing block
`ifndef DSC_DECODE_DEFINES_VH
`define DSC_DECODE_DEFINES_VH

// instruction word layout
`define INSTR_W          24
`define LONG_W           48
`define OPC_HI           23
`define OPC_LO           16
`define CLS_HI           23
`define CLS_LO           20
`define SUB_HI           19
`define SUB_LO           16

// operation classes held in the upper opcode nibble
`define CLS_NOP          4'h0
`define CLS_ADD3         4'h1
`define CLS_ADDC3        4'h2
`define CLS_ADDLIT       4'h3
`define CLS_ADDCLIT      4'h4
`define CLS_ADDF         4'h5
`define CLS_ADDCF        4'h6
`define CLS_BIT          4'h7
`define CLS_MAC          4'h8
`define CLS_ACC          4'h9
`define CLS_FLOW         4'hA
`define CLS_SKIP         4'hB
`define CLS_LONG         4'hC

// flow-change sub codes
`define FLOW_COND        4'h0
`define FLOW_UNCOND      4'h1
`define FLOW_COMPUTED    4'h2
`define FLOW_INDIRECT    4'h3
`define FLOW_TABLE       4'h4
`define FLOW_RETURN      4'h5
`define FLOW_INT_EXIT    4'h6
`define FLOW_MOVE_PAIR   4'h7

// two-word sub codes, low two bits
`define LONG_JUMP        2'h0
`define LONG_CALL        2'h1
`define LONG_LOOP        2'h2

// extra no-operation cycles
`define EXTRA_NONE       2'h0
`define EXTRA_ONE        2'h1
`define EXTRA_TWO        2'h2

// operand modes and literal limits
`define MODE_LITERAL     3'h7
`define TEN_BIT_LITERAL_BYTE_MAX   10'h0FF

// fixed working registers and prefetch codes
`define W_FILE_OP        4'h0
`define W_MULT_BASE      4'h4
`define W_X_BASE         4'h8
`define W_Y_BASE         4'hA
`define W_INDEX          4'hC
`define PF_CODE_INDEXED  4'hE
`define PF_CODE_NONE     4'hF
`define PF_SECOND_REG    4'h7

// accumulator write-back selections
`define AWB_NONE         2'h0
`define AWB_DIRECT       2'h1
`define AWB_POST_INC2    2'h2

`endif

// ### rtl/dsc_instruction_decode_timing.v
// instruction decode, cycle timing and status flag logic of the core
//
// Summary of operation
// - each single word is 24 bits; 8-bit opcode picks the operation type
// - three instructions span two words, 48 bits from consecutive places
// - second word has zero upper byte; executed alone it is a no-op
// - every two-word instruction takes exactly two cycles
// - single words take one cycle, two when branch taken, extra is a no-op
// - jumps, indirect calls, table ops and returns take two or three cycles
// - a taken skip costs two cycles, or three over a two-word instruction
// - register-pair moves take two cycles
// - three-operand forms decode base, source plus mode, destination plus mode
// - file ops decode address up to 0x1FFF, result to file or register 0
// - bit ops take the bit from a 4-bit literal or the base register
// - multiply pairs are one of six pairs from registers 4 to 7
// - square pairs use one register from 4 to 7 for both operands
// - x prefetch uses register 8 or 9, adjusted, indexed by 12, or none
// - y prefetch uses register 10 or 11; prefetch targets are 4 to 7
// - accumulator write-back goes to register 13 or its address plus 2
// - 10-bit literal up to 255 in byte mode, 1023 in word; 5-bit to 31
// - carry, digit carry, negative, overflow and sticky zero flags kept
// - accumulator adds touch only the four accumulator flags
// - signed add puts a shifted 16-bit source into the chosen accumulator
// - carry sums add the carry and update all five core flags
`timescale 1ns/1ps
`include "dsc_decode_defines.vh"

module dsc_instruction_decode_timing #(
	parameter ACC_W = 40
) (
	input  wire               clk,
	input  wire               sys_rst,
	input  wire [23:0]        instr_word,
	input  wire               instr_valid,
	output wire               instr_ready,
	input  wire               branch_cond,
	input  wire               skip_cond,
	input  wire [15:0]        operand_a,
	input  wire [15:0]        operand_b,
	output reg                exec_valid_r,
	output reg                exec_nop_r,
	output reg  [3:0]         exec_class_r,
	output reg  [1:0]         exec_cycles_r,
	output reg  [47:0]        long_instr_r,
	output reg                long_valid_r,
	output reg                illegal_r,
	output reg                byte_mode_r,
	output reg  [3:0]         base_operand_reg_r,
	output reg  [3:0]         source_operand_reg_r,
	output reg  [2:0]         source_mode_r,
	output reg  [3:0]         dest_operand_reg_r,
	output reg  [2:0]         dest_mode_r,
	output reg  [12:0]        file_addr_r,
	output reg                file_op_work_reg_r,
	output reg  [3:0]         bit_select_field_r,
	output reg                bit_indirect_r,
	output reg  [9:0]         ten_bit_literal_r,
	output reg  [4:0]         five_bit_literal_r,
	output reg                literal_err_r,
	output reg  [2:0]         dsp_mult_pair_r,
	output reg  [3:0]         mult_m_reg_r,
	output reg  [3:0]         mult_n_reg_r,
	output reg                x_enable_r,
	output reg                x_indexed_r,
	output reg  [3:0]         x_prefetch_addr_r,
	output reg  [3:0]         x_adjust_r,
	output reg  [3:0]         x_dest_r,
	output reg                y_enable_r,
	output reg                y_indexed_r,
	output reg  [3:0]         y_prefetch_addr_r,
	output reg  [3:0]         y_adjust_r,
	output reg  [3:0]         y_dest_r,
	output reg  [1:0]         acc_writeback_reg_r,
	output reg                acc_sel_r,
	output reg  [15:0]        alu_result_r,
	output reg                carry_flag_r,
	output reg                digit_carry_flag_r,
	output reg                negative_flag_r,
	output reg                signed_wrap_flag_r,
	output reg                zero_flag_r,
	output reg                acc_a_wrap_flag_r,
	output reg                acc_b_wrap_flag_r,
	output reg                acc_a_clip_flag_r,
	output reg                acc_b_clip_flag_r,
	output reg  [ACC_W-1:0]   acc_a_r,
	output reg  [ACC_W-1:0]   acc_b_r
);

////////////////////////////////////////////////////////////////////////////////
// states and helpers

localparam [4:0] ST_RUN   = 5'h01;
localparam [4:0] ST_WORD2 = 5'h02;
localparam [4:0] ST_NOP   = 5'h04;
localparam [4:0] ST_SKIP  = 5'h08;
localparam [4:0] ST_SKIP2 = 5'h10;

// {c, dc, n, ov, z, result}
function [20:0] add16;
	input [15:0] a;
	input [15:0] b;
	input        cin;
	input        bmode;
	reg   [16:0] s;
	reg   [4:0]  lo;
	reg   [8:0]  sb;
	begin
		s  = {1'b0, a} + {1'b0, b} + {16'h0000, cin};
		lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
		sb = {1'b0, a[7:0]} + {1'b0, b[7:0]} + {8'h00, cin};
		if (bmode) begin
			add16 = {sb[8], lo[4], sb[7],
				(a[7] == b[7]) && (sb[7] != a[7]),
				(sb[7:0] == 8'h00), a[15:8], sb[7:0]};
		end else begin
			add16 = {s[16], lo[4], s[15],
				(a[15] == b[15]) && (s[15] != a[15]),
				(s[15:0] == 16'h0000), s[15:0]};
		end
	end
endfunction

// {wrap, clip, value}; clip saturates at the full accumulator width
function [ACC_W+1:0] acc_add;
	input [ACC_W-1:0] x;
	input [ACC_W-1:0] y;
	reg   [ACC_W:0]   s;
	reg   [ACC_W-1:0] v;
	reg               sat;
	begin
		s   = {x[ACC_W-1], x} + {y[ACC_W-1], y};
		sat = s[ACC_W] ^ s[ACC_W-1];
		v   = sat ? {s[ACC_W], {(ACC_W-1){~s[ACC_W]}}} : s[ACC_W-1:0];
		acc_add = {~((&v[ACC_W-1:31]) | ~(|v[ACC_W-1:31])), sat, v};
	end
endfunction

// {enable, indexed, register, signed post-adjust}
function [9:0] pf_decode;
	input [3:0] code;
	input [3:0] base;
	reg   [3:0] m;
	begin
		m = (code >= `PF_SECOND_REG) ? code - `PF_SECOND_REG : code;
		case (m)
			4'h1:    pf_decode[3:0] = 4'h2;
			4'h2:    pf_decode[3:0] = 4'h4;
			4'h3:    pf_decode[3:0] = 4'h6;
			4'h4:    pf_decode[3:0] = 4'hE;
			4'h5:    pf_decode[3:0] = 4'hC;
			4'h6:    pf_decode[3:0] = 4'hA;
			default: pf_decode[3:0] = 4'h0;
		endcase
		pf_decode[7:4] = (code >= `PF_SECOND_REG) ? base + 4'h1 : base;
		pf_decode[8]   = (code == `PF_CODE_INDEXED);
		pf_decode[9]   = (code != `PF_CODE_NONE);
		if (code == `PF_CODE_INDEXED)
			pf_decode[3:0] = 4'h0;
		if (code == `PF_CODE_NONE)
			pf_decode[7:0] = 8'h00;
	end
endfunction

// {illegal, m register, n register}
function [8:0] mult_pair;
	input       square;
	input [2:0] p;
	begin
		mult_pair = 9'h000;
		if (square) begin
			mult_pair[7:4] = `W_MULT_BASE + {2'b00, p[1:0]};
			mult_pair[3:0] = `W_MULT_BASE + {2'b00, p[1:0]};
			mult_pair[8]   = p[2];
		end else begin
			case (p)
				3'h0:    mult_pair[7:0] = 8'h45;
				3'h1:    mult_pair[7:0] = 8'h46;
				3'h2:    mult_pair[7:0] = 8'h47;
				3'h3:    mult_pair[7:0] = 8'h56;
				3'h4:    mult_pair[7:0] = 8'h57;
				3'h5:    mult_pair[7:0] = 8'h67;
				default: mult_pair[8]   = 1'b1;
			endcase
		end
	end
endfunction

function is_long;
	input [23:0] w;
	begin
		is_long = (w[`CLS_HI:`CLS_LO] == `CLS_LONG) && (w[17:16] != 2'h3);
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
// word decode

reg  [4:0]  state_r;
reg  [1:0]  nop_left_r;
wire [3:0]  cls = instr_word[`CLS_HI:`CLS_LO];
wire [3:0]  sub = instr_word[`SUB_HI:`SUB_LO];
wire        take = instr_valid & instr_ready;

// the fetch path is held only while padding cycles run
assign instr_ready = (state_r != ST_NOP);

reg  [15:0]      add_b;
reg              add_cin;
reg              add_bmode;
reg              is_carry_summing_op;
reg              is_alu;
reg  [20:0]      add_out;
reg  [1:0]       extra;
reg              bad;
reg  [ACC_W-1:0] src_ext;
reg  signed [ACC_W-1:0] src_sr;
reg  [ACC_W-1:0] src_sh;
reg  [ACC_W+1:0] acc_res;
reg  [9:0]       xpf;
reg  [9:0]       ypf;
reg  [8:0]       pair;

always @* begin
	is_alu    = 1'b0;
	is_carry_summing_op   = (cls == `CLS_ADDC3) || (cls == `CLS_ADDCLIT) ||
		(cls == `CLS_ADDCF);
	add_bmode = sub[3];
	add_b     = operand_b;
	case (cls)
		`CLS_ADD3, `CLS_ADDC3: begin
			is_alu = 1'b1;
			if (instr_word[11:9] == `MODE_LITERAL)
				add_b = {11'h000, instr_word[8:4]};
		end
		`CLS_ADDLIT, `CLS_ADDCLIT: begin
			is_alu = 1'b1;
			add_b  = {6'h00, instr_word[13:4]};
		end
		`CLS_ADDF, `CLS_ADDCF: is_alu = 1'b1;
		default: is_alu = 1'b0;
	endcase
	add_cin = is_carry_summing_op & carry_flag_r;
	add_out = add16(operand_a, add_b, add_cin, add_bmode);
	// source sits in the upper fraction word, then shifted by the literal
	src_ext = {{(ACC_W-32){operand_a[15]}}, operand_a, 16'h0000};
	src_sr  = $signed(src_ext) >>> instr_word[10:8];
	if (instr_word[11])
		src_sh = src_ext << (4'h0 - instr_word[11:8]);
	else
		src_sh = src_sr;
	if (!sub[3])
		acc_res = sub[0] ? acc_add(acc_b_r, acc_a_r) :
			acc_add(acc_a_r, acc_b_r);
	else
		acc_res = sub[0] ? acc_add(acc_b_r, src_sh) :
			acc_add(acc_a_r, src_sh);
	xpf  = pf_decode(instr_word[12:9], `W_X_BASE);
	ypf  = pf_decode(instr_word[6:3], `W_Y_BASE);
	pair = mult_pair(sub[3], instr_word[15:13]);
	extra = `EXTRA_NONE;
	bad   = 1'b0;
	case (cls)
		`CLS_FLOW: begin
			case (sub)
				`FLOW_COND:
					extra = branch_cond ? `EXTRA_ONE : `EXTRA_NONE;
				`FLOW_UNCOND, `FLOW_COMPUTED, `FLOW_INDIRECT,
				`FLOW_TABLE:
					extra = `EXTRA_ONE;
				`FLOW_MOVE_PAIR:
					extra = `EXTRA_ONE;
				`FLOW_RETURN, `FLOW_INT_EXIT:
					extra = `EXTRA_TWO;
				default: bad = 1'b1;
			endcase
		end
		`CLS_LONG: bad = (sub[1:0] == 2'h3);
		`CLS_MAC: bad = pair[8] || (sub[2:1] == 2'h3);
		default: bad = (cls > `CLS_LONG);
	endcase
end

////////////////////////////////////////////////////////////////////////////////
// sequencer

always @(posedge clk or posedge sys_rst) begin
	if (sys_rst) begin
		state_r       <= ST_RUN;
		nop_left_r    <= 2'h0;
		exec_valid_r  <= 1'b0;
		exec_nop_r    <= 1'b0;
		exec_class_r  <= `CLS_NOP;
		exec_cycles_r <= 2'h0;
		long_instr_r  <= 48'h000000000000;
		long_valid_r  <= 1'b0;
		illegal_r     <= 1'b0;
	end else begin
		exec_valid_r <= 1'b0;
		exec_nop_r   <= 1'b0;
		long_valid_r <= 1'b0;
		illegal_r    <= 1'b0;
		case (state_r)
			ST_RUN: begin
				if (take) begin
					exec_valid_r  <= 1'b1;
					exec_class_r  <= cls;
					exec_nop_r    <= (cls == `CLS_NOP);
					illegal_r     <= bad;
					exec_cycles_r <= 2'h1 + extra;
					long_instr_r[47:24] <= instr_word;
					if (is_long(instr_word)) begin
						exec_cycles_r <= 2'h2;
						state_r       <= ST_WORD2;
					end else if (cls == `CLS_SKIP && skip_cond) begin
						exec_cycles_r <= 2'h2;
						state_r       <= ST_SKIP;
					end else if (extra != `EXTRA_NONE) begin
						nop_left_r <= extra;
						state_r    <= ST_NOP;
					end
				end
			end
			ST_WORD2: begin
				if (take) begin
					long_instr_r[23:0] <= instr_word;
					long_valid_r       <= 1'b1;
					state_r            <= ST_RUN;
				end
			end
			ST_NOP: begin
				exec_nop_r <= 1'b1;
				nop_left_r <= nop_left_r - 2'h1;
				if (nop_left_r == 2'h1)
					state_r <= ST_RUN;
			end
			ST_SKIP: begin
				if (take) begin
					exec_nop_r <= 1'b1;
					if (is_long(instr_word)) begin
						exec_cycles_r <= 2'h3;
						state_r       <= ST_SKIP2;
					end else begin
						state_r <= ST_RUN;
					end
				end
			end
			ST_SKIP2: begin
				if (take) begin
					exec_nop_r <= 1'b1;
					state_r    <= ST_RUN;
				end
			end
			default: state_r <= ST_RUN;
		endcase
	end
end

////////////////////////////////////////////////////////////////////////////////
// operand fields

wire run_take = take && (state_r == ST_RUN);

always @(posedge clk or posedge sys_rst) begin
	if (sys_rst) begin
		byte_mode_r          <= 1'b0;
		base_operand_reg_r   <= 4'h0;
		source_operand_reg_r <= 4'h0;
		source_mode_r        <= 3'h0;
		dest_operand_reg_r   <= 4'h0;
		dest_mode_r          <= 3'h0;
		file_addr_r          <= 13'h0000;
		file_op_work_reg_r   <= 1'b0;
		bit_select_field_r   <= 4'h0;
		bit_indirect_r       <= 1'b0;
		ten_bit_literal_r    <= 10'h000;
		five_bit_literal_r   <= 5'h00;
		literal_err_r        <= 1'b0;
		dsp_mult_pair_r      <= 3'h0;
		mult_m_reg_r         <= 4'h0;
		mult_n_reg_r         <= 4'h0;
		{x_enable_r, x_indexed_r, x_prefetch_addr_r, x_adjust_r} <= 10'h000;
		{y_enable_r, y_indexed_r, y_prefetch_addr_r, y_adjust_r} <= 10'h000;
		x_dest_r             <= 4'h0;
		y_dest_r             <= 4'h0;
		acc_writeback_reg_r  <= `AWB_NONE;
		acc_sel_r            <= 1'b0;
	end else if (run_take) begin
		byte_mode_r   <= sub[3] && is_alu;
		literal_err_r <= 1'b0;
		acc_sel_r     <= sub[0];
		case (cls)
			`CLS_ADD3, `CLS_ADDC3: begin
				base_operand_reg_r   <= instr_word[15:12];
				source_mode_r        <= instr_word[11:9];
				source_operand_reg_r <= instr_word[8:5];
				five_bit_literal_r   <= instr_word[8:4];
				dest_operand_reg_r   <= instr_word[3:0];
				dest_mode_r          <= sub[2:0];
			end
			`CLS_ADDLIT, `CLS_ADDCLIT: begin
				ten_bit_literal_r  <= instr_word[13:4];
				dest_operand_reg_r <= instr_word[3:0];
				dest_mode_r        <= 3'h0;
				literal_err_r      <= sub[3] &&
					(instr_word[13:4] > `TEN_BIT_LITERAL_BYTE_MAX);
			end
			`CLS_ADDF, `CLS_ADDCF: begin
				file_addr_r        <= instr_word[12:0];
				file_op_work_reg_r <= instr_word[13];
				dest_operand_reg_r <= `W_FILE_OP;
			end
			`CLS_BIT: begin
				bit_indirect_r       <= sub[3];
				bit_select_field_r   <= instr_word[15:12];
				source_operand_reg_r <= instr_word[11:8];
				base_operand_reg_r   <= instr_word[7:4];
				source_mode_r        <= instr_word[3:1];
			end
			`CLS_MAC: begin
				dsp_mult_pair_r <= instr_word[15:13];
				mult_m_reg_r    <= pair[7:4];
				mult_n_reg_r    <= pair[3:0];
				{x_enable_r, x_indexed_r, x_prefetch_addr_r,
					x_adjust_r} <= xpf;
				{y_enable_r, y_indexed_r, y_prefetch_addr_r,
					y_adjust_r} <= ypf;
				x_dest_r <= `W_MULT_BASE + {2'b00, instr_word[8:7]};
				y_dest_r <= `W_MULT_BASE + {2'b00, instr_word[2:1]};
				acc_writeback_reg_r <= (sub[2:1] == 2'h3) ?
					`AWB_NONE : sub[2:1];
			end
			`CLS_ACC: begin
				source_operand_reg_r <= instr_word[15:12];
			end
			default: literal_err_r <= 1'b0;
		endcase
	end
end

////////////////////////////////////////////////////////////////////////////////
// status flags and accumulators

always @(posedge clk or posedge sys_rst) begin
	if (sys_rst) begin
		alu_result_r       <= 16'h0000;
		carry_flag_r       <= 1'b0;
		digit_carry_flag_r <= 1'b0;
		negative_flag_r    <= 1'b0;
		signed_wrap_flag_r <= 1'b0;
		zero_flag_r        <= 1'b0;
		acc_a_wrap_flag_r  <= 1'b0;
		acc_b_wrap_flag_r  <= 1'b0;
		acc_a_clip_flag_r  <= 1'b0;
		acc_b_clip_flag_r  <= 1'b0;
		acc_a_r            <= {ACC_W{1'b0}};
		acc_b_r            <= {ACC_W{1'b0}};
	end else if (run_take) begin
		if (is_alu) begin
			alu_result_r       <= add_out[15:0];
			carry_flag_r       <= add_out[20];
			digit_carry_flag_r <= add_out[19];
			negative_flag_r    <= add_out[18];
			signed_wrap_flag_r <= add_out[17];
			// carry sums may only clear zero, never set it
			zero_flag_r <= is_carry_summing_op ? (zero_flag_r & add_out[16]) :
				add_out[16];
		end
		if (cls == `CLS_ACC) begin
			if (sub[0]) begin
				acc_b_r           <= acc_res[ACC_W-1:0];
				acc_b_wrap_flag_r <= acc_res[ACC_W+1];
				acc_b_clip_flag_r <= acc_b_clip_flag_r | acc_res[ACC_W];
			end else begin
				acc_a_r           <= acc_res[ACC_W-1:0];
				acc_a_wrap_flag_r <= acc_res[ACC_W+1];
				acc_a_clip_flag_r <= acc_a_clip_flag_r | acc_res[ACC_W];
			end
		end
	end
end

endmodule // dsc_instruction_decode_timing

// ### sim/dsc_decode_sva.sv
// timing and flag assertions on the decode block ports
`timescale 1ns/1ps
module dsc_decode_sva (
	input wire       clk,
	input wire       sys_rst,
	input wire       instr_valid,
	input wire       instr_ready,
	input wire       exec_valid_r,
	input wire       exec_nop_r,
	input wire [3:0] exec_class_r,
	input wire [1:0] exec_cycles_r,
	input wire       long_valid_r,
	input wire       illegal_r,
	input wire       carry_flag_r,
	input wire       zero_flag_r
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	wire flow = exec_valid_r && exec_class_r == 4'hA;
	wire two = exec_valid_r && exec_class_r == 4'hC && !illegal_r;
	wire carry_op = exec_valid_r && (exec_class_r == 4'h2 ||
		exec_class_r == 4'h4 || exec_class_r == 4'h6);
	////////////////////////////////////////////////////////////////
	AST_PAD_NOP: assert property (!instr_ready |=> exec_nop_r)
		else $error("padding cycle not run as a nop");
	AST_ONE_CYCLE: assert property (exec_valid_r &&
		exec_cycles_r == 2'h1 |-> instr_ready)
		else $error("single cycle word held the fetch");
	AST_FLOW_TWO: assert property (flow && exec_cycles_r == 2'h2
		|-> !instr_ready ##1 instr_ready)
		else $error("two cycle flow word padded wrongly");
	AST_FLOW_THREE: assert property (flow && exec_cycles_r == 2'h3
		|-> !instr_ready [*2] ##1 instr_ready)
		else $error("three cycle flow word padded wrongly");
	AST_LONG_CYCLES: assert property (two |-> exec_cycles_r == 2'h2)
		else $error("two word instruction not two cycles");
	AST_LONG_PAIR: assert property (two && !exec_nop_r &&
		instr_valid && instr_ready |=> long_valid_r && !exec_valid_r)
		else $error("second word not joined to the first");
	AST_LONE_NOP: assert property (exec_valid_r &&
		exec_class_r == 4'h0 |-> exec_nop_r)
		else $error("lone second word not a nop");
	AST_ZERO_STICKY: assert property ($rose(zero_flag_r) |->
		exec_valid_r && !carry_op)
		else $error("carry sum set the zero flag");
	AST_ACC_CORE: assert property (exec_valid_r &&
		exec_class_r == 4'h9 |-> $stable(carry_flag_r) &&
		$stable(zero_flag_r))
		else $error("accumulator add touched core flags");
	cover property (long_valid_r);
	cover property (flow && exec_cycles_r == 2'h3);
	cover property (exec_valid_r && exec_class_r == 4'hB ##1 exec_nop_r
		##1 exec_nop_r);
endmodule // dsc_decode_sva

bind dsc_instruction_decode_timing dsc_decode_sva u_sva (.*);

// ### sim/fetch_model.sv
// program memory fetch model feeding words and their conditions
`timescale 1ns/1ps
module fetch_model (
	input  wire        clk,
	input  wire        push,
	input  wire [25:0] push_data,
	input  wire        instr_ready,
	output wire [23:0] instr_word,
	output wire        instr_valid,
	output wire        branch_cond,
	output wire        skip_cond,
	output wire        idle
);
	reg  [25:0] mem_r [0:63];
	reg  [25:0] last_r = 26'h0000000;
	reg  [5:0]  rd_r = 6'h00;
	reg  [5:0]  wr_r = 6'h00;
	wire [25:0] cur;

	// an idle bus shows the inverse of the last word, not a stale copy
	assign cur         = instr_valid ? mem_r[rd_r] : ~last_r;
	assign instr_valid = rd_r != wr_r;
	assign idle        = !instr_valid;
	assign instr_word  = cur[23:0];
	assign branch_cond = cur[25];
	assign skip_cond   = cur[24];

	always @(posedge clk) begin
		if (push) begin
			mem_r[wr_r] <= push_data;
			wr_r <= wr_r + 6'h01;
		end
		if (instr_valid && instr_ready) begin
			rd_r <= rd_r + 6'h01;
			last_r <= cur;
		end
	end
endmodule // fetch_model

// ### sim/dsc_instruction_decode_timing_tb_top.sv
// self-checking bench for the decode and cycle timing block
`timescale 1ns/1ps
module dsc_instruction_decode_timing_tb_top;
	localparam [23:0] m_tab = 24'h655444;
	localparam [23:0] n_tab = 24'h776765;
	localparam [15:0] cyc_tab = 16'hBEAA;
	reg         clk;
	reg         sys_rst;
	reg  [15:0] operand_a;
	reg  [15:0] operand_b;
	reg         push;
	reg  [25:0] push_data;
	reg  [4:0]  fl;
	wire        idle, instr_valid, instr_ready, branch_cond, skip_cond;
	wire        exec_valid_r, exec_nop_r, long_valid_r, illegal_r;
	wire        byte_mode_r, file_op_work_reg_r, bit_indirect_r;
	wire        literal_err_r, x_enable_r, x_indexed_r, y_enable_r;
	wire        y_indexed_r, acc_sel_r, carry_flag_r, digit_carry_flag_r;
	wire        negative_flag_r, signed_wrap_flag_r, zero_flag_r;
	wire        acc_a_wrap_flag_r, acc_b_wrap_flag_r;
	wire        acc_a_clip_flag_r, acc_b_clip_flag_r;
	wire [3:0]  exec_class_r, base_operand_reg_r, source_operand_reg_r;
	wire [3:0]  dest_operand_reg_r, bit_select_field_r, mult_m_reg_r;
	wire [3:0]  mult_n_reg_r, x_prefetch_addr_r, x_adjust_r, x_dest_r;
	wire [3:0]  y_prefetch_addr_r, y_adjust_r, y_dest_r;
	wire [2:0]  source_mode_r, dest_mode_r, dsp_mult_pair_r;
	wire [1:0]  exec_cycles_r, acc_writeback_reg_r;
	wire [23:0] instr_word;
	wire [47:0] long_instr_r;
	wire [12:0] file_addr_r;
	wire [9:0]  ten_bit_literal_r;
	wire [4:0]  five_bit_literal_r;
	wire [15:0] alu_result_r;
	wire [39:0] acc_a_r, acc_b_r;
	wire [4:0]  flags = {carry_flag_r, digit_carry_flag_r,
		negative_flag_r, signed_wrap_flag_r, zero_flag_r};
	int         errors = 0, n_checks = 0, nops = 0, pads = 0, longs = 0;
	int         ills = 0;
	int         n0, p0, l0, s;

	dsc_instruction_decode_timing #(.ACC_W(40)) DUT (.*);
	fetch_model pm (.*);

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	always @(posedge clk) begin
		if (!instr_ready) pads++;
		if (exec_nop_r) nops++;
		if (long_valid_r) longs++;
		if (illegal_r) ills++;
	end
	////////////////////////////////////////////////////////////////
	task chk(input string nm, input logic [47:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask

	task put(input [25:0] d);
		@(posedge clk);
		push <= 1'b1;
		push_data <= d;
	endtask

	// drain the queue, then one edge more so trailing pulses are counted
	task go;
		int k;
		@(posedge clk);
		push <= 1'b0;
		k = 0;
		do begin
			@(posedge clk);
			#1;
			k++;
		end while (!(idle && instr_ready) && k < 20);
		if (k >= 20) errors++;
		@(posedge clk);
		#1;
	endtask

	task mark;
		n0 = nops;
		p0 = pads;
		l0 = longs;
	endtask

	task end_of_test;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		sys_rst = 1'b1;
		push = 1'b0;
		push_data = 26'h0000000;
		operand_a = 16'hFFFF;
		operand_b = 16'h0001;
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		put(26'h01032A6);
		go;
		chk("base", base_operand_reg_r, 4'h3);
		chk("smode", source_mode_r, 3'h1);
		chk("src", source_operand_reg_r, 4'h5);
		chk("dest", dest_operand_reg_r, 4'h6);
		chk("sum", alu_result_r, 16'h0000);
		chk("flags", flags, 5'h19);
		chk("cls", exec_class_r, 4'h1);
		operand_a <= 16'h0000;
		operand_b <= 16'h0000;
		put(26'h02032A6);
		go;
		chk("carry_summing_op", {alu_result_r, flags}, 21'h00020);
		put(26'h02032A6);
		go;
		chk("sticky", {alu_result_r, flags}, 21'h0);
		operand_a <= 16'h12FF;
		operand_b <= 16'h0001;
		put(26'h01B32A6);
		go;
		chk("bsum", {byte_mode_r, alu_result_r}, 17'h11200);
		chk("dmode", dest_mode_r, 3'h3);
		$display("test add done");
		put(26'h0503FFF);
		go;
		chk("file", {file_op_work_reg_r, file_addr_r}, 14'h3FFF);
		put(26'h0381002);
		go;
		chk("lit", {literal_err_r, ten_bit_literal_r}, 11'h500);
		put(26'h0303FF2);
		go;
		chk("lit", {literal_err_r, ten_bit_literal_r}, 11'h3FF);
		put(26'h0100FF1);
		go;
		chk("five_bit_literal", five_bit_literal_r, 5'h1F);
		put(26'h078F000);
		go;
		chk("bit", {bit_indirect_r, bit_select_field_r}, 5'h1F);
		$display("test fields done");
		fl = flags;
		operand_a <= 16'h4000;
		put(26'h0980000);
		put(26'h0980000);
		put(26'h0910000);
		go;
		chk("acca", acc_a_r, 40'h0080000000);
		chk("accb", acc_b_r, 40'h0080000000);
		chk("dsp", {acc_a_wrap_flag_r, acc_b_wrap_flag_r,
			acc_a_clip_flag_r, acc_b_clip_flag_r}, 4'hC);
		chk("core", flags, fl);
		put(26'h0980F00);
		go;
		chk("shl", acc_a_r, 40'h0100000000);
		for (s = 0; s < 6; s++) begin
			put({2'h0, 8'h85, s[2:0], 13'h0366});
			go;
			chk("m", mult_m_reg_r, m_tab[s*4+:4]);
			chk("n", mult_n_reg_r, n_tab[s*4+:4]);
			chk("pr", dsp_mult_pair_r, s[2:0]);
		end
		chk("x", {x_enable_r, x_indexed_r, x_prefetch_addr_r,
			x_adjust_r, x_dest_r}, 14'h2826);
		chk("y", {y_enable_r, y_indexed_r, y_prefetch_addr_r,
			y_adjust_r, y_dest_r}, 14'h2BC7);
		chk("awb", {acc_writeback_reg_r, acc_sel_r}, 3'h5);
		put(26'h0801C78);
		go;
		chk("xidx", {x_indexed_r, y_enable_r}, 2'h2);
		for (s = 0; s < 4; s++) begin
			put({2'h0, 8'h8D, s[2:0], 13'h0366});
			go;
			chk("sq", {mult_m_reg_r, mult_n_reg_r}, {2{4'h4 + s[3:0]}});
		end
		$display("test dsp done");
		for (s = 0; s < 8; s++) begin
			mark;
			put({2'h2, 4'hA, s[3:0], 16'h0000});
			go;
			chk("cyc", exec_cycles_r, cyc_tab[s*2+:2]);
			chk("pad", pads - p0, cyc_tab[s*2+:2] - 1);
			chk("nop", nops - n0, cyc_tab[s*2+:2] - 1);
		end
		put(26'h0A00000);
		go;
		chk("ntk", exec_cycles_r, 2'h1);
		$display("test flow done");
		mark;
		put(26'h0C01234);
		put(26'h0005678);
		go;
		chk("long", long_instr_r, 48'hC01234005678);
		chk("lcyc", exec_cycles_r, 2'h2);
		chk("lcnt", longs - l0, 1);
		mark;
		put(26'h0005678);
		go;
		chk("lone", nops - n0, 1);
		mark;
		put(26'h1B00000);
		put(26'h0C01234);
		put(26'h0005678);
		go;
		chk("skp3", exec_cycles_r, 2'h3);
		chk("skn3", {nops - n0, longs - l0}, 64'h200000000);
		mark;
		put(26'h1B00000);
		put(26'h01032A6);
		go;
		chk("skp2", exec_cycles_r, 2'h2);
		chk("skn2", nops - n0, 1);
		put(26'h0B00000);
		go;
		chk("skn", exec_cycles_r, 2'h1);
		chk("ill0", ills, 0);
		put(26'h0D00000);
		go;
		chk("ill", ills, 1);
		$display("test skip done");
		end_of_test;
	end

	initial begin
		repeat (5000) @(posedge clk);
		errors++;
		end_of_test;
	end
endmodule // dsc_instruction_decode_timing_tb_top
